// ---- dcs_pkg.sv ----
// constants and types shared by the sync pulse and capture unit
package dcs_pkg;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] ADR_PWIDTH_LO   = 12'h982;
	localparam logic [11:0] ADR_PWIDTH_HI   = 12'h983;
	localparam logic [11:0] ADR_ACT_STAT    = 12'h984;
	localparam logic [11:0] ADR_STAT_FIRST  = 12'h98E;
	localparam logic [11:0] ADR_STAT_SECOND = 12'h98F;
	localparam logic [11:0] ADR_START_BASE  = 12'h990;
	localparam logic [11:0] ADR_NEXT2_BASE  = 12'h998;
	localparam logic [11:0] ADR_PERIOD_BASE = 12'h9A0;
	localparam logic [11:0] ADR_DELAY_BASE  = 12'h9A4;
	localparam logic [11:0] ADR_CAPA_CTRL   = 12'h9A8;
	localparam logic [11:0] ADR_CAPB_CTRL   = 12'h9A9;
	localparam logic [11:0] ADR_CAPA_STAT   = 12'h9AE;
	localparam logic [11:0] ADR_CAPB_STAT   = 12'h9AF;
	localparam logic [11:0] ADR_TIME_A_POS  = 12'h9B0;
	localparam logic [11:0] ADR_TIME_A_NEG  = 12'h9B8;
	localparam logic [11:0] ADR_TIME_B_POS  = 12'h9C0;
	localparam logic [11:0] ADR_TIME_B_NEG  = 12'h9C8;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int ACT_PEND_FIRST_BIT  = 0;
	localparam int ACT_PEND_SECOND_BIT = 1;
	localparam int ACT_PLAUS_BIT       = 2;
	localparam int LAT_POS_BIT         = 0;
	localparam int LAT_NEG_BIT         = 1;
	localparam int LAT_PIN_BIT         = 2;
	localparam int NEAR_SHORT_BIT      = 31;
	localparam int NEAR_LONG_BIT       = 63;

	// ---------------------------------------------------------------
	// reset values and timing
	// ---------------------------------------------------------------
	localparam logic [63:0] RST_TIME   = 64'h0000_0000_0000_0000;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          WIDTH_STEP_NS = 10;

	// ---------------------------------------------------------------
	// sync sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_DONE  = 2'b10
	} dcs_sync_st_t;

endpackage : dcs_pkg

// ---- dcs_lat_if.sv ----
// carrier between the top and one capture input unit
interface dcs_lat_if;
	logic [1:0] single_mode;
	logic [1:0] rd_clr;
	logic [1:0] flags;
	logic [1:0] cap_stb;
	logic       pin_lvl;

	modport unit (input single_mode, input rd_clr, output flags, output cap_stb, output pin_lvl);
	modport ctrl (output single_mode, output rd_clr, input flags, input cap_stb, input pin_lvl);
endinterface : dcs_lat_if

// ---- dcs_pulse.sv ----
// one timed sync output with width counter and acknowledge mode
module dcs_pulse
	import dcs_pkg::*;
#(
	parameter int NS_W = 24
)(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// control
	input  wire logic        fire,
	input  wire logic [15:0] width,
	input  wire logic        ack,
	// pin
	output logic             pulse_o
);

	initial
	begin
		if (NS_W < 21)
			$error("dcs_pulse: NS_W too small for 16-bit width in 10 ns steps");
	end

	logic            active_r;
	logic            active_nxt;
	logic [NS_W-1:0] ns_r;
	logic [NS_W-1:0] ns_nxt;
	logic [NS_W-1:0] limit;

	assign limit = NS_W'(width) * NS_W'(WIDTH_STEP_NS);

	always_comb
	begin
		active_nxt = active_r;
		ns_nxt     = ns_r;
		if (fire)
		begin
			active_nxt = 1'b1;
			ns_nxt     = '0;
		end
		else if (active_r)
		begin
			if (width == 16'h0000)
			begin
				if (ack)
					active_nxt = 1'b0;
			end
			else
			begin
				ns_nxt = ns_r + NS_W'(CLK_PERIOD_NS);
				if (ns_nxt >= limit)
					active_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			active_r <= 1'b0;
			ns_r     <= '0;
		end
		else
		begin
			active_r <= active_nxt;
			ns_r     <= ns_nxt;
		end
	end

	assign pulse_o = active_r;

endmodule : dcs_pulse

// ---- dcs_latch.sv ----
// one capture input: synchroniser, edge detect, single/continuous mode
module dcs_latch
	import dcs_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// pin
	input  wire logic pin,
	// carrier
	dcs_lat_if.unit   lif
);

	logic       meta_r;
	logic       sync_r;
	logic       prev_r;
	logic [1:0] hit;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else
		begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign hit[LAT_POS_BIT] = sync_r & ~prev_r;
	assign hit[LAT_NEG_BIT] = ~sync_r & prev_r;
	assign lif.pin_lvl      = prev_r;

	// ---------------------------------------------------------------
	// per-edge flag and capture strobe
	// ---------------------------------------------------------------
	for (genvar e = 0; e < 2; e++)
	begin : g_edge
		logic flag_r;
		logic flag_nxt;
		logic stb_r;
		logic stb_nxt;

		always_comb
		begin
			flag_nxt = flag_r;
			stb_nxt  = 1'b0;
			if (!lif.single_mode[e])
				flag_nxt = 1'b0;
			else if (lif.rd_clr[e])
				flag_nxt = 1'b0;
			if (hit[e] && (!lif.single_mode[e] || !flag_r || lif.rd_clr[e]))
			begin
				stb_nxt = 1'b1;
				if (lif.single_mode[e])
					flag_nxt = 1'b1;
			end
		end

		always_ff @(posedge mclk)
		begin
			if (sys_rst)
			begin
				flag_r <= 1'b0;
				stb_r  <= 1'b0;
			end
			else
			begin
				flag_r <= flag_nxt;
				stb_r  <= stb_nxt;
			end
		end

		assign lif.flags[e]   = flag_r;
		assign lif.cap_stb[e] = stb_r;
	end

endmodule : dcs_latch

// ---- dcs_unit.sv ----
// sync pulse generator and capture input unit, top level
// Function
// - pulse width is 16 bits in 10 ns steps
// - zero width keeps output high until its status register is read
// - per-output status bit shows first pulse still pending
// - activation records whether start time lay outside near future
// - without write-ack, host status read clears event request bit
// - with write-ack, host status write clears event request bit
// - start-time write sets start; read returns next first-output time
// - start time writable only while unit inactive
// - auto-activation extends lower-only start write to 64 bits
// - read-only next second-output time register
// - 32-bit first-output period; zero means single shot
// - 32-bit delay from first pulse to second pulse
// - start and period written only by owning interface
// - per-edge control selects continuous or single-event capture
// - capture control written only by that unit's owner
// - edge flag set only in single-event mode
// - edge flag cleared when its captured time is read by the unit's owner, or instead written by a host owner under write-ack
// - sync owner bit zero network side, one local host
// - capture interrupt routed by unit ownership bit
// - each qualifying edge strobes a system time capture
module dcs_unit
	import dcs_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// network side register port
	input  wire logic [11:0] net_addr,
	input  wire logic        net_rd,
	input  wire logic        net_wr,
	input  wire logic [7:0]  net_wdata,
	output logic      [7:0]  net_rdata,
	// local host port
	input  wire logic [11:0] host_addr,
	input  wire logic        host_rd,
	input  wire logic        host_wr,
	input  wire logic [7:0]  host_wdata,
	output logic      [7:0]  host_rdata,
	// configuration held outside
	input  wire logic        unit_active,
	input  wire logic        first_gen_en,
	input  wire logic        second_gen_en,
	input  wire logic        auto_act_en,
	input  wire logic        plaus_chk_en,
	input  wire logic        near_future_short,
	input  wire logic        sync_owner_host,
	input  wire logic        cap_a_owner_host,
	input  wire logic        cap_b_owner_host,
	input  wire logic        host_wr_ack_en,
	input  wire logic [15:0] pulse_width_cfg,
	input  wire logic        frame_end,
	input  wire logic [63:0] system_time,
	// pins
	input  wire logic        capture_input_a,
	input  wire logic        capture_input_b,
	output logic             first_pulse_output,
	output logic             second_pulse_output,
	// events
	output logic      [1:0]  app_evreq,
	output logic             auto_activate_set,
	output logic      [1:0]  cap_a_stb,
	output logic      [1:0]  cap_b_stb,
	output logic             latch_irq_net,
	output logic             latch_irq_host
);

	// ---------------------------------------------------------------
	// owner write select
	// ---------------------------------------------------------------
	logic        s_wr;
	logic [11:0] s_addr;
	logic [7:0]  s_data;
	logic        a_wr;
	logic        b_wr;

	assign s_wr   = sync_owner_host ? host_wr : net_wr;
	assign s_addr = sync_owner_host ? host_addr : net_addr;
	assign s_data = sync_owner_host ? host_wdata : net_wdata;
	assign a_wr   = cap_a_owner_host ? (host_wr && host_addr == ADR_CAPA_CTRL)
		: (net_wr && net_addr == ADR_CAPA_CTRL);
	assign b_wr   = cap_b_owner_host ? (host_wr && host_addr == ADR_CAPB_CTRL)
		: (net_wr && net_addr == ADR_CAPB_CTRL);

	// ---------------------------------------------------------------
	// sync sequencer
	// ---------------------------------------------------------------
	dcs_sync_st_t st_r, st_nxt;
	logic [63:0] next0_r, next0_nxt;
	logic [63:0] next1_r, next1_nxt;
	logic [31:0] period_r, period_nxt;
	logic [31:0] delay_r, delay_nxt;
	logic [1:0]  pend_r, pend_nxt;
	logic        plaus_r, plaus_nxt;
	logic        imm_r, imm_nxt;
	logic        arm1_r, arm1_nxt;
	logic        act_d_r;
	logic        lo_wr_r, lo_wr_nxt;
	logic        hi_wr_r, hi_wr_nxt;
	logic        autoset_r, autoset_nxt;
	logic [1:0]  fire_r, fire_nxt;
	logic [1:0]  evreq_r, evreq_nxt;
	logic [63:0] ahead;
	logic [63:0] late0;
	logic [63:0] late1;
	logic        outside;
	logic        st_win;

	assign ahead   = next0_r - system_time;
	assign late0   = system_time - next0_r;
	assign late1   = system_time - next1_r;
	assign outside = near_future_short ? (|ahead[63:NEAR_SHORT_BIT]) : ahead[NEAR_LONG_BIT];
	assign st_win  = s_wr && !unit_active && s_addr[11:3] == ADR_START_BASE[11:3];

	always_comb
	begin
		st_nxt      = st_r;
		next0_nxt   = next0_r;
		next1_nxt   = next1_r;
		period_nxt  = period_r;
		delay_nxt   = delay_r;
		pend_nxt    = pend_r;
		plaus_nxt   = plaus_r;
		imm_nxt     = imm_r;
		arm1_nxt    = arm1_r;
		lo_wr_nxt   = lo_wr_r;
		hi_wr_nxt   = hi_wr_r;
		autoset_nxt = 1'b0;
		fire_nxt    = 2'b00;
		evreq_nxt   = evreq_r;
		if (st_win)
		begin
			next0_nxt[8*s_addr[2:0] +: 8] = s_data;
			if (s_addr[2])
				hi_wr_nxt = 1'b1;
			else
				lo_wr_nxt = 1'b1;
		end
		if (s_wr && s_addr[11:2] == ADR_PERIOD_BASE[11:2])
			period_nxt[8*s_addr[1:0] +: 8] = s_data;
		if (s_wr && s_addr[11:2] == ADR_DELAY_BASE[11:2])
			delay_nxt[8*s_addr[1:0] +: 8] = s_data;
		if (frame_end)
		begin
			if (auto_act_en && (lo_wr_r || hi_wr_r) && !unit_active)
			begin
				autoset_nxt = 1'b1;
				if (!hi_wr_r)
					next0_nxt[63:32] = system_time[63:32]
						+ {31'h0000_0000, (next0_r[31:0] < system_time[31:0])};
			end
			lo_wr_nxt = 1'b0;
			hi_wr_nxt = 1'b0;
		end
		case (st_r)
			ST_IDLE:
			begin
				if (unit_active && !act_d_r)
				begin
					plaus_nxt = outside;
					imm_nxt   = plaus_chk_en && outside;
					pend_nxt  = {second_gen_en, first_gen_en};
					arm1_nxt  = 1'b0;
					st_nxt    = ST_ARMED;
				end
			end
			ST_ARMED:
			begin
				if (imm_r || !late0[63])
				begin
					imm_nxt     = 1'b0;
					fire_nxt[0] = first_gen_en;
					pend_nxt[0] = 1'b0;
					next1_nxt   = next0_r + {32'h0000_0000, delay_r};
					arm1_nxt    = 1'b1;
					if (period_r == RST_WORD)
						st_nxt = ST_DONE;
					else
						next0_nxt = next0_r + {32'h0000_0000, period_r};
				end
			end
			ST_DONE:
			begin
			end
			default:
				st_nxt = ST_IDLE;
		endcase
		if (st_r != ST_IDLE && arm1_r && !late1[63] && fire_nxt[0] == 1'b0)
		begin
			fire_nxt[1] = second_gen_en;
			pend_nxt[1] = 1'b0;
			next1_nxt   = next1_r + {32'h0000_0000, period_r};
			arm1_nxt    = 1'b0;
		end
		if (!unit_active)
		begin
			st_nxt   = ST_IDLE;
			pend_nxt = 2'b00;
			arm1_nxt = 1'b0;
			imm_nxt  = 1'b0;
		end
		if (host_wr_ack_en ? (host_wr && host_addr == ADR_STAT_FIRST)
			: (host_rd && host_addr == ADR_STAT_FIRST))
			evreq_nxt[0] = 1'b0;
		if (host_wr_ack_en ? (host_wr && host_addr == ADR_STAT_SECOND)
			: (host_rd && host_addr == ADR_STAT_SECOND))
			evreq_nxt[1] = 1'b0;
		evreq_nxt = evreq_nxt | fire_nxt;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st_r      <= ST_IDLE;
			next0_r   <= RST_TIME;
			next1_r   <= RST_TIME;
			period_r  <= RST_WORD;
			delay_r   <= RST_WORD;
			pend_r    <= 2'b00;
			plaus_r   <= 1'b0;
			imm_r     <= 1'b0;
			arm1_r    <= 1'b0;
			act_d_r   <= 1'b0;
			lo_wr_r   <= 1'b0;
			hi_wr_r   <= 1'b0;
			autoset_r <= 1'b0;
			fire_r    <= 2'b00;
			evreq_r   <= 2'b00;
		end
		else
		begin
			st_r      <= st_nxt;
			next0_r   <= next0_nxt;
			next1_r   <= next1_nxt;
			period_r  <= period_nxt;
			delay_r   <= delay_nxt;
			pend_r    <= pend_nxt;
			plaus_r   <= plaus_nxt;
			imm_r     <= imm_nxt;
			arm1_r    <= arm1_nxt;
			act_d_r   <= unit_active;
			lo_wr_r   <= lo_wr_nxt;
			hi_wr_r   <= hi_wr_nxt;
			autoset_r <= autoset_nxt;
			fire_r    <= fire_nxt;
			evreq_r   <= evreq_nxt;
		end
	end

	assign app_evreq         = evreq_r;
	assign auto_activate_set = autoset_r;

	// ---------------------------------------------------------------
	// sync outputs
	// ---------------------------------------------------------------
	logic [1:0] ack;

	assign ack[0] = (net_rd && net_addr == ADR_STAT_FIRST)
		|| (host_rd && host_addr == ADR_STAT_FIRST);
	assign ack[1] = (net_rd && net_addr == ADR_STAT_SECOND)
		|| (host_rd && host_addr == ADR_STAT_SECOND);

	dcs_pulse #(.NS_W(24)) u_first (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.fire    (fire_r[0]),
		.width   (pulse_width_cfg),
		.ack     (ack[0]),
		.pulse_o (first_pulse_output)
	);

	dcs_pulse #(.NS_W(24)) u_second (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.fire    (fire_r[1]),
		.width   (pulse_width_cfg),
		.ack     (ack[1]),
		.pulse_o (second_pulse_output)
	);

	// ---------------------------------------------------------------
	// capture inputs
	// ---------------------------------------------------------------
	dcs_lat_if lif_a ();
	dcs_lat_if lif_b ();
	logic [1:0] ctrl_a_r, ctrl_a_nxt;
	logic [1:0] ctrl_b_r, ctrl_b_nxt;
	logic [1:0] irq_r, irq_nxt;

	function automatic logic clr_hit(input logic own, input logic [11:0] a);
		logic h;
		h = 1'b0;
		if (own)
			h = host_wr_ack_en ? (host_wr && host_addr == a) : (host_rd && host_addr == a);
		else
			h = net_rd && net_addr == a;
		return h;
	endfunction : clr_hit

	assign lif_a.single_mode = ctrl_a_r;
	assign lif_b.single_mode = ctrl_b_r;
	assign lif_a.rd_clr = {clr_hit(cap_a_owner_host, ADR_TIME_A_NEG),
		clr_hit(cap_a_owner_host, ADR_TIME_A_POS)};
	assign lif_b.rd_clr = {clr_hit(cap_b_owner_host, ADR_TIME_B_NEG),
		clr_hit(cap_b_owner_host, ADR_TIME_B_POS)};

	always_comb
	begin
		ctrl_a_nxt = a_wr ? s_data_a() : ctrl_a_r;
		ctrl_b_nxt = b_wr ? s_data_b() : ctrl_b_r;
		irq_nxt[0] = (!cap_a_owner_host && |lif_a.cap_stb)
			|| (!cap_b_owner_host && |lif_b.cap_stb);
		irq_nxt[1] = (cap_a_owner_host && |lif_a.cap_stb)
			|| (cap_b_owner_host && |lif_b.cap_stb);
	end

	function automatic logic [1:0] s_data_a();
		return cap_a_owner_host ? host_wdata[1:0] : net_wdata[1:0];
	endfunction : s_data_a

	function automatic logic [1:0] s_data_b();
		return cap_b_owner_host ? host_wdata[1:0] : net_wdata[1:0];
	endfunction : s_data_b

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			ctrl_a_r <= 2'b00;
			ctrl_b_r <= 2'b00;
			irq_r    <= 2'b00;
		end
		else
		begin
			ctrl_a_r <= ctrl_a_nxt;
			ctrl_b_r <= ctrl_b_nxt;
			irq_r    <= irq_nxt;
		end
	end

	assign latch_irq_net  = irq_r[0];
	assign latch_irq_host = irq_r[1];
	assign cap_a_stb      = lif_a.cap_stb;
	assign cap_b_stb      = lif_b.cap_stb;

	dcs_latch u_cap_a (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.pin     (capture_input_a),
		.lif     (lif_a.unit)
	);

	dcs_latch u_cap_b (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.pin     (capture_input_b),
		.lif     (lif_b.unit)
	);

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	logic [7:0] net_rd_r, net_rd_nxt;
	logic [7:0] host_rd_r, host_rd_nxt;

	function automatic logic [7:0] rd_byte(input logic [11:0] a);
		logic [7:0] d;
		d = RST_BYTE;
		if (a == ADR_PWIDTH_LO)
			d = pulse_width_cfg[7:0];
		else if (a == ADR_PWIDTH_HI)
			d = pulse_width_cfg[15:8];
		else if (a == ADR_ACT_STAT)
			d = {5'h00, plaus_r, pend_r};
		else if (a == ADR_STAT_FIRST)
			d = {7'h00, pend_r[0]};
		else if (a == ADR_STAT_SECOND)
			d = {7'h00, pend_r[1]};
		else if (a[11:3] == ADR_START_BASE[11:3])
			d = next0_r[8*a[2:0] +: 8];
		else if (a[11:3] == ADR_NEXT2_BASE[11:3])
			d = next1_r[8*a[2:0] +: 8];
		else if (a[11:2] == ADR_PERIOD_BASE[11:2])
			d = period_r[8*a[1:0] +: 8];
		else if (a[11:2] == ADR_DELAY_BASE[11:2])
			d = delay_r[8*a[1:0] +: 8];
		else if (a == ADR_CAPA_CTRL)
			d = {6'h00, ctrl_a_r};
		else if (a == ADR_CAPB_CTRL)
			d = {6'h00, ctrl_b_r};
		else if (a == ADR_CAPA_STAT)
			d = {5'h00, lif_a.pin_lvl, lif_a.flags};
		else if (a == ADR_CAPB_STAT)
			d = {5'h00, lif_b.pin_lvl, lif_b.flags};
		return d;
	endfunction : rd_byte

	always_comb
	begin
		net_rd_nxt  = net_rd ? rd_byte(net_addr) : net_rd_r;
		host_rd_nxt = host_rd ? rd_byte(host_addr) : host_rd_r;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			net_rd_r  <= RST_BYTE;
			host_rd_r <= RST_BYTE;
		end
		else
		begin
			net_rd_r  <= net_rd_nxt;
			host_rd_r <= host_rd_nxt;
		end
	end

	assign net_rdata  = net_rd_r;
	assign host_rdata = host_rd_r;

endmodule : dcs_unit

// ---- dcs_far.sv ----
// far side model: free-running system time and frame boundary marks
module dcs_far
	import dcs_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// time base
	output logic      [63:0] system_time,
	output logic             frame_end
);
	logic [63:0] st_r;
	logic [5:0]  fc_r;

	always_ff @(posedge mclk)
	begin
		st_r <= sys_rst ? 64'h0000_0000_0000_1000 : st_r + 64'(CLK_PERIOD_NS);
		fc_r <= sys_rst ? 6'h00 : fc_r + 6'h01;
	end

	assign system_time = st_r;
	assign frame_end   = (fc_r == 6'h3F);
endmodule : dcs_far

// ---- dcs_unit_chk.sv ----
// port assertions for the sync pulse and capture unit
module dcs_unit_chk
	import dcs_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// register ports
	input wire logic [11:0] net_addr,
	input wire logic        net_rd,
	input wire logic [7:0]  net_rdata,
	input wire logic [11:0] host_addr,
	input wire logic        host_rd,
	input wire logic [7:0]  host_rdata,
	// configuration
	input wire logic        unit_active,
	input wire logic [15:0] pulse_width_cfg,
	input wire logic        cap_a_owner_host,
	// outputs
	input wire logic        first_pulse_output,
	input wire logic [1:0]  app_evreq,
	input wire logic        auto_activate_set,
	input wire logic [1:0]  cap_a_stb,
	input wire logic        latch_irq_net,
	input wire logic        latch_irq_host
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	logic        st_rd;
	logic [15:0] hi_r;
	logic [15:0] hi_nxt;

	assign st_rd = (net_rd && net_addr == ADR_STAT_FIRST) || (host_rd && host_addr == ADR_STAT_FIRST);
	always_comb hi_nxt = first_pulse_output ? hi_r + 16'h0001 : 16'h0000;
	always_ff @(posedge mclk) hi_r <= sys_rst ? 16'h0000 : hi_nxt;

	width_exact_a: assert property ($fell(first_pulse_output) && pulse_width_cfg != 16'h0000
		|-> 20'(hi_r) == (20'(pulse_width_cfg) * 20'h0000A + 20'h00007) / 20'h00008)
		else $error("pulse width wrong");
	ack_hold_a: assert property (first_pulse_output && pulse_width_cfg == 16'h0000 && unit_active
		&& !st_rd |=> first_pulse_output) else $error("ack pulse ended early");
	evreq_pulse_a: assert property ($rose(app_evreq[0]) |-> ##[0:1] $rose(first_pulse_output))
		else $error("event request without pulse");
	strobe_one_a: assert property (cap_a_stb[0] |-> !cap_a_stb[1] ##1 !cap_a_stb[0])
		else $error("capture strobe too long");
	irq_route_a: assert property (|cap_a_stb |=> (cap_a_owner_host ? latch_irq_host : latch_irq_net))
		else $error("capture irq misrouted");
	auto_once_a: assert property (auto_activate_set |=> !auto_activate_set)
		else $error("activation pulse too long");
	net_hold_a: assert property (!net_rd |=> $stable(net_rdata))
		else $error("net read data moved");
	host_hold_a: assert property (!host_rd |=> $stable(host_rdata))
		else $error("host read data moved");

	cover property ($rose(first_pulse_output));
	cover property (st_rd && first_pulse_output);
	cover property (cap_a_stb[0]);
endmodule : dcs_unit_chk

bind dcs_unit dcs_unit_chk dcs_unit_chk_i (.*);

// ---- test_dcs_unit.sv ----
// self-checking bench for the sync pulse and capture unit
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module test_dcs_unit import dcs_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk, sys_rst, net_rd, net_wr, host_rd, host_wr, unit_active, first_gen_en;
	logic        second_gen_en, auto_act_en, plaus_chk_en, near_future_short, sync_owner_host;
	logic        cap_a_owner_host, cap_b_owner_host, host_wr_ack_en, frame_end, capture_input_a;
	logic        capture_input_b, first_pulse_output, second_pulse_output, auto_activate_set;
	logic        latch_irq_net, latch_irq_host, fp_d;
	logic [11:0] net_addr, host_addr;
	logic [7:0]  net_wdata, host_wdata, net_rdata, host_rdata, d;
	logic [15:0] pulse_width_cfg;
	logic [63:0] system_time, t0, per, dly;
	logic [1:0]  app_evreq, cap_a_stb, cap_b_stb;
	logic [31:0] seed;
	logic [7:0]  mreg [int];
	logic [11:0] ra [9] = '{ADR_ACT_STAT, ADR_STAT_FIRST, ADR_STAT_SECOND, ADR_START_BASE,
		ADR_NEXT2_BASE, ADR_PERIOD_BASE, ADR_DELAY_BASE, ADR_CAPA_CTRL, ADR_CAPA_STAT};
	int          error_cnt = 0, n_tests = 0, cyc = 0, nstb = 0, nrise = 0, nact = 0, n, n0;

	dcs_unit dcs_unit_i (.*);
	dcs_far dcs_far_i (.mclk(mclk), .sys_rst(sys_rst), .system_time(system_time), .frame_end(frame_end));

	always #4 mclk = ~mclk;
	always @(posedge mclk)
	begin
		fp_d <= first_pulse_output;
		nrise <= nrise + int'(first_pulse_output && !fp_d);
		nstb <= nstb + int'(cap_a_stb[0]);
		nact <= nact + int'(auto_activate_set);
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			error_cnt++;
			results();
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// model: which writes land
	function automatic logic okw(input logic h, input logic [11:0] a);
		if (a >= ADR_START_BASE && a < ADR_NEXT2_BASE)
			return h == sync_owner_host && !unit_active;
		if (a >= ADR_PERIOD_BASE && a < ADR_CAPA_CTRL)
			return h == sync_owner_host;
		return a == ADR_CAPA_CTRL && h == cap_a_owner_host;
	endfunction : okw

	function automatic logic [63:0] mv(input logic [11:0] a);
		mv = 64'h0;
		for (int i = 7; i >= 0; i--)
			mv = {mv[55:0], mreg.exists(a + 12'(i)) ? mreg[a + 12'(i)] : 8'h00};
	endfunction : mv

	task automatic cy(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cy

	task automatic acc(input logic h, input logic w, input logic [11:0] a, input logic [7:0] wd);
		{net_addr, host_addr, net_wdata, host_wdata} = {a, a, wd, wd};
		{net_rd, net_wr, host_rd, host_wr} = {!h && !w, !h && w, h && !w, h && w};
		cy(1);
		{net_rd, net_wr, host_rd, host_wr} = 4'h0;
		d = h ? host_rdata : net_rdata;
		cy(1);
	endtask : acc

	task automatic rchk(input logic h, input logic [11:0] a, input logic [63:0] v, input int k);
		for (int i = 0; i < k; i++)
		begin
			acc(h, 1'b0, a + 12'(i), 8'h00);
			`CHK(d, v[8*i +: 8])
		end
	endtask : rchk

	task automatic wq(input logic h, input logic [11:0] a, input logic [63:0] v, input int k);
		for (int i = 0; i < k; i++)
		begin
			if (okw(h, a))
				mreg[a + 12'(i)] = (a == ADR_CAPA_CTRL) ? v[7:0] & 8'h03 : v[8*i +: 8];
			acc(h, 1'b1, a + 12'(i), v[8*i +: 8]);
		end
	endtask : wq

	task automatic wt(input logic k);
		for (int i = 0; i < 3000 && (k ? second_pulse_output : first_pulse_output) !== 1'b1; i++)
			cy(1);
	endtask : wt

	task automatic results();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	initial
	begin
		{mclk, net_rd, net_wr, host_rd, host_wr, net_addr, host_addr, net_wdata, host_wdata} = '0;
		{unit_active, first_gen_en, second_gen_en, auto_act_en, plaus_chk_en} = '0;
		{near_future_short, sync_owner_host, cap_a_owner_host, cap_b_owner_host} = '0;
		{host_wr_ack_en, capture_input_a, capture_input_b} = '0;
		pulse_width_cfg = 16'h0003;
		sys_rst = 1'b1;
		seed = 32'h0000BB63;
		cy(8);
		sys_rst = 1'b0;
		// ------------------------------------------------
		// reset values and register access
		// ------------------------------------------------
		foreach (ra[i])
			rchk(1'b0, ra[i], 64'h0, 1);
		rchk(1'b1, ADR_PWIDTH_LO, 64'h3, 2);
		per = 64'(8 * (160 + xs() % 32));
		dly = per >> 2;
		t0 = system_time + 64'h800;
		wq(1'b1, ADR_PERIOD_BASE, 64'hFF, 4);
		wq(1'b0, ADR_PERIOD_BASE, per, 4);
		wq(1'b0, ADR_DELAY_BASE, dly, 4);
		wq(1'b0, ADR_START_BASE, t0, 8);
		rchk(1'b1, ADR_PERIOD_BASE, mv(ADR_PERIOD_BASE), 4);
		rchk(1'b1, ADR_DELAY_BASE, mv(ADR_DELAY_BASE), 4);
		// ------------------------------------------------
		// cyclic pulses, requests and next times
		// ------------------------------------------------
		{first_gen_en, second_gen_en, unit_active} = 3'h7;
		cy(3);
		rchk(1'b0, ADR_ACT_STAT, 64'h03, 1);
		wq(1'b0, ADR_START_BASE, 64'h0, 8);
		rchk(1'b0, ADR_START_BASE, t0, 8);
		wt(1'b0);
		`CHK(system_time - t0 < 64'h20, 1'b1)
		for (n = 0; first_pulse_output; n++)
			cy(1);
		`CHK(n, (3 * WIDTH_STEP_NS + 7) / 8)
		acc(1'b1, 1'b1, ADR_STAT_FIRST, 8'h00);
		`CHK(app_evreq[0], 1'b1)
		acc(1'b1, 1'b0, ADR_STAT_FIRST, 8'h00);
		`CHK(app_evreq[0], 1'b0)
		rchk(1'b0, ADR_ACT_STAT, 64'h02, 1);
		rchk(1'b0, ADR_START_BASE, t0 + per, 8);
		wt(1'b1);
		`CHK(system_time - t0 - dly < 64'h20, 1'b1)
		host_wr_ack_en = 1'b1;
		acc(1'b1, 1'b1, ADR_STAT_SECOND, 8'h00);
		`CHK(app_evreq[1], 1'b0)
		cy(8);
		rchk(1'b0, ADR_ACT_STAT, 64'h00, 1);
		rchk(1'b1, ADR_NEXT2_BASE, t0 + per + dly, 8);
		// ------------------------------------------------
		// single shot, acknowledge mode, plausibility
		// ------------------------------------------------
		{unit_active, second_gen_en, host_wr_ack_en} = 3'h0;
		{pulse_width_cfg, plaus_chk_en, near_future_short} = {16'h0000, 2'h3};
		cy(2);
		t0 = system_time + 64'h1_0000_0000;
		wq(1'b0, ADR_PERIOD_BASE, 64'h0, 4);
		wq(1'b0, ADR_START_BASE, t0, 8);
		n0 = nrise;
		unit_active = 1'b1;
		wt(1'b0);
		`CHK(system_time < t0, 1'b1)
		acc(1'b0, 1'b0, ADR_ACT_STAT, 8'h00);
		`CHK(d[ACT_PLAUS_BIT], 1'b1)
		cy(20);
		`CHK(first_pulse_output, 1'b1)
		acc(1'b0, 1'b0, ADR_STAT_FIRST, 8'h00);
		cy(2);
		`CHK(first_pulse_output, 1'b0)
		cy(300);
		`CHK(nrise - n0, 1)
		// ------------------------------------------------
		// capture inputs and auto-activation
		// ------------------------------------------------
		wq(1'b1, ADR_CAPA_CTRL, 64'h03, 1);
		wq(1'b0, ADR_CAPA_CTRL, 64'h01, 1);
		rchk(1'b1, ADR_CAPA_CTRL, mv(ADR_CAPA_CTRL), 1);
		n0 = nstb;
		capture_input_a = 1'b1;
		cy(6);
		rchk(1'b0, ADR_CAPA_STAT, 64'h05, 1);
		capture_input_a = 1'b0;
		cy(6);
		capture_input_a = 1'b1;
		cy(6);
		`CHK(nstb - n0, 1)
		rchk(1'b0, ADR_CAPA_STAT, 64'h05, 1);
		acc(1'b0, 1'b0, ADR_TIME_A_POS, 8'h00);
		rchk(1'b0, ADR_CAPA_STAT, 64'h04, 1);
		cap_b_owner_host = 1'b1;
		capture_input_b = xs() % 2;
		cy(6);
		rchk(1'b1, ADR_CAPB_STAT, 64'({capture_input_b, 2'b00}), 1);
		{unit_active, auto_act_en} = 2'h1;
		t0 = {32'h0000_0000, system_time[31:0] + 32'h0000_1000};
		wait (frame_end);
		cy(1);
		wq(1'b0, ADR_START_BASE, t0, 4);
		cy(64);
		`CHK(nact, 1)
		rchk(1'b0, ADR_START_BASE, t0, 8);
		results();
	end
endmodule : test_dcs_unit
